// ---- rtl/hprw_top.sv ----
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module hprw_top #(
  parameter int TICK_DIV = hprw_pkg::TICK_DIV,
  parameter int PWM_DIV = hprw_pkg::PWM_DIV
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // AXI4-Lite slave
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // General pins, pin 2 power control, pin 3 host reset
  input wire logic [hprw_pkg::GPIO_N-1:0] i_gpio,
  output logic [hprw_pkg::GPIO_N-1:0] o_gpio_o,
  output logic [hprw_pkg::GPIO_N-1:0] o_gpio_oe,
  // Keypad and supply sense
  input wire logic i_rail_sense,
  input wire logic i_key_confirm,
  input wire logic i_key_cancel,
  // System side
  output logic o_blank,
  output logic o_restart,
  output logic [17:0] o_baud
);
  import hprw_pkg::*;

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic awrdy;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } hprw_bus_t;

  typedef struct packed {
    hprw_bus_t bus;
    logic [7:0] fn;
    logic [7:0] plen;
    logic ssel;
    logic [7:0] wd_to;
    logic [7:0] wd_cnt;
    logic [5:0] wd_sec;
    logic [17:0] baud;
    logic [17:0] baud_act;
    logic [GPIO_N-1:0][6:0] duty;
    logic [GPIO_N-1:0] ufn;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] pdiv;
    logic [6:0] pwm_cnt;
    logic [GPIO_N-1:0] gin;
    logic [GPIO_N-1:0] rise;
    logic [GPIO_N-1:0] fall;
    hprw_st_t st;
    logic [7:0] hold;
    logic wdr;
    logic sense_q;
    logic idle_p;
    logic idle_r;
    logic restart;
    logic blank;
    logic [GPIO_N-1:0] gpio_o;
    logic [GPIO_N-1:0] gpio_oe;
  } hprw_state_t;

  function automatic hprw_state_t hprw_init();
    hprw_state_t s;
    s = '0;
    s.fn = FN_RST;
    s.plen = PLEN_RST;
    s.ssel = 1'b1;
    s.baud = BAUD_RST;
    s.baud_act = BAUD_RST;
    // Sense assumed high so a powered host does not retrigger a restart.
    s.sense_q = 1'b1;
    s.idle_p = 1'b1;
    s.idle_r = 1'b1;
    s.st = ST_IDLE;
    return s;
  endfunction

  hprw_state_t r;
  hprw_state_t n;
  logic sense;
  logic tick;
  logic ptick;
  logic pwr_drv;
  logic rst_drv;
  logic pact;
  logic ract;
  logic wd_act;
  logic [2:0] gidx;
  hprw_bus_t bus_keep;

  assign sense = r.ssel ? i_rail_sense : i_gpio[PIN_SENSE];
  assign tick = (r.div == DIV_W'(TICK_DIV - 1));
  assign ptick = (r.pdiv == DIV_W'(PWM_DIV - 1));
  assign wd_act = (r.wd_to != 8'h00);
  assign gidx = i_wdata[2:0];

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    bus_keep = '0;
    pwr_drv = 1'b0;
    rst_drv = 1'b0;
    pact = 1'b0;
    ract = 1'b0;
    n = r;
    n.restart = 1'b0;
    n.bus.awrdy = 1'b0;
    n.bus.arrdy = 1'b0;
    n.div = tick ? '0 : r.div + 1'b1;
    n.pdiv = ptick ? '0 : r.pdiv + 1'b1;
    n.sense_q = sense;
    if (ptick) begin
      n.pwm_cnt = (r.pwm_cnt == PWM_LAST) ? '0 : r.pwm_cnt + 1'b1;
    end

    case (r.st)
      ST_IDLE: begin
        n.hold = '0;
        n.wdr = 1'b0;
        if (i_key_confirm && !sense && r.fn[FN_KON]) begin
          n.st = ST_HOLD_ON;
        end else if (i_key_confirm && sense && r.fn[FN_KRST]) begin
          n.st = ST_HOLD_RST;
        end else if (i_key_cancel && sense && r.fn[FN_KOFF]) begin
          n.st = ST_HOLD_OFF;
        end
      end
      ST_HOLD_ON: begin
        if (!i_key_confirm) begin
          n.st = ST_IDLE;
        end else if (r.hold >= PWRON_TICKS) begin
          n.st = ST_PON;
          n.hold = '0;
        end else if (tick) begin
          n.hold = r.hold + 1'b1;
        end
      end
      ST_HOLD_RST: begin
        if (!i_key_confirm) begin
          n.st = ST_IDLE;
        end else if (r.hold >= HOLD_TICKS) begin
          n.st = ST_PRST;
          n.hold = '0;
        end else if (tick) begin
          n.hold = r.hold + 1'b1;
        end
      end
      ST_HOLD_OFF: begin
        if (!i_key_cancel) begin
          n.st = ST_IDLE;
        end else if (r.hold >= HOLD_TICKS) begin
          n.st = ST_POFF;
          n.hold = '0;
        end else if (tick) begin
          n.hold = r.hold + 1'b1;
        end
      end
      ST_PON: begin
        if (r.hold >= r.plen) begin
          n.st = ST_IDLE;
          n.restart = 1'b1;
        end else if (tick) begin
          n.hold = r.hold + 1'b1;
        end
      end
      ST_POFF: begin
        if (r.hold >= r.plen) begin
          n.st = i_key_cancel ? ST_PEXT : ST_IDLE;
          n.hold = '0;
        end else if (tick) begin
          n.hold = r.hold + 1'b1;
        end
      end
      ST_PEXT: begin
        if (!i_key_cancel || r.hold >= EXT_TICKS) begin
          n.st = ST_IDLE;
        end else if (tick) begin
          n.hold = r.hold + 1'b1;
        end
      end
      ST_PRST: begin
        if (r.hold >= RSTP_TICKS) begin
          n.st = ST_IDLE;
          n.restart = !r.wdr;
        end else if (tick) begin
          n.hold = r.hold + 1'b1;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase

    if (wd_act && r.wd_cnt == 8'h00) begin
      n.wd_to = '0;
      n.st = ST_PRST;
      n.hold = '0;
      n.wdr = 1'b1;
    end else if (wd_act && tick) begin
      n.wd_sec = (r.wd_sec == SEC_LAST) ? '0 : r.wd_sec + 1'b1;
      if (r.wd_sec == SEC_LAST) begin
        n.wd_cnt = r.wd_cnt - 1'b1;
      end
    end

    // AXI4-Lite write: address and data are taken together.
    if (i_awvalid && i_wvalid && !r.bus.awrdy && !r.bus.bvalid) begin
      n.bus.awrdy = 1'b1;
    end
    if (r.bus.bvalid && i_bready) begin
      n.bus.bvalid = 1'b0;
      n.baud_act = r.baud;
    end
    if (r.bus.awrdy) begin
      n.bus.bvalid = 1'b1;
      n.bus.bresp = RESP_OKAY;
      case (i_awaddr)
        // absent byte lanes keep their value in CFG and WDOG; BAUD takes all 18 bits on lane 0 alone, GCFG ignores strobes
        A_CFG: begin
          if (i_wstrb[0]) begin
            n.fn = i_wdata[7:0];
          end
          if (i_wstrb[1]) begin
            n.plen = i_wdata[15:8];
          end
          if (i_wstrb[2]) begin
            n.ssel = i_wdata[16];
          end
        end
        A_WDOG: begin
          if (i_wstrb[0]) begin
            n.wd_to = i_wdata[7:0];
            n.wd_cnt = i_wdata[7:0];
            n.wd_sec = '0;
          end
        end
        A_BAUD: begin
          if (i_wstrb[0]) begin
            n.baud = i_wdata[17:0];
          end
        end
        A_GCFG: begin
          if (gidx < 3'(GPIO_N) && i_wdata[14:8] <= DUTY_MAX) begin
            n.duty[gidx] = i_wdata[14:8];
            n.ufn[gidx] = i_wdata[16];
          end
        end
        default: begin
          n.bus.bresp = RESP_SLVERR;
        end
      endcase
    end

    // AXI4-Lite read.
    if (i_arvalid && !r.bus.arrdy && !r.bus.rvalid) begin
      n.bus.arrdy = 1'b1;
    end
    if (r.bus.rvalid && i_rready) begin
      n.bus.rvalid = 1'b0;
    end
    if (r.bus.arrdy) begin
      n.bus.rvalid = 1'b1;
      n.bus.rresp = RESP_OKAY;
      n.bus.rdata = '0;
      case (i_araddr)
        A_CFG: n.bus.rdata = {15'h0000, r.ssel, r.plen, r.fn};
        A_WDOG: n.bus.rdata = {23'h00_0000, wd_act, r.wd_cnt};
        A_BAUD: n.bus.rdata = {14'h0000, r.baud};
        A_GSTAT: begin
          n.bus.rdata = {11'h000, r.fall, 3'h0, r.rise, 3'h0, r.gin};
          n.rise = '0;
          n.fall = '0;
        end
        A_DBG1: n.bus.rdata = {r.fn | (8'(wd_act) << FN_WDACT), 24'h00_0000};
        A_DBG2: n.bus.rdata = {7'h00, r.ssel, 16'h0000, r.wd_cnt};
        A_GCFG, A_DBG0, A_DBG3: n.bus.rdata = '0;
        default: n.bus.rresp = RESP_SLVERR;
      endcase
    end

    // slow sampling, set wins over query clear
    if (tick) begin
      n.gin = i_gpio;
      n.rise = n.rise | (i_gpio & ~r.gin);
      n.fall = n.fall | (~i_gpio & r.gin);
    end

    if (sense && !r.sense_q) begin
      n.restart = 1'b1;
    end
    // The bus side survives a restart so no handshake is left hanging.
    if (r.restart) begin
      bus_keep = n.bus;
      n = hprw_init();
      n.bus = bus_keep;
    end

    // idle level captured only while undriven
    if (!r.gpio_oe[PIN_PWR]) begin
      n.idle_p = i_gpio[PIN_PWR];
    end
    if (!r.gpio_oe[PIN_RST]) begin
      n.idle_r = i_gpio[PIN_RST];
    end
    pact = n.fn[FN_AUTO] ? !r.idle_p : n.fn[FN_PINV];
    ract = n.fn[FN_AUTO] ? !r.idle_r : n.fn[FN_RINV];
    pwr_drv = (n.st == ST_PON) || (n.st == ST_POFF) || (n.st == ST_PEXT);
    rst_drv = (n.st == ST_PRST);
    for (int i = 0; i < GPIO_N; i++) begin
      n.gpio_oe[i] = n.ufn[i];
      n.gpio_o[i] = n.ufn[i] && (n.pwm_cnt < n.duty[i]);
    end
    if (!n.ufn[PIN_PWR]) begin
      n.gpio_oe[PIN_PWR] = pwr_drv;
      n.gpio_o[PIN_PWR] = pwr_drv && pact;
    end
    if (!n.ufn[PIN_RST]) begin
      n.gpio_oe[PIN_RST] = rst_drv;
      n.gpio_o[PIN_RST] = rst_drv && ract;
    end
    n.blank = n.fn[FN_BLANK] && !sense;
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_b) begin
      r <= hprw_init();
    end else begin
      r <= n;
    end
  end

  assign o_awready = r.bus.awrdy;
  assign o_wready = r.bus.awrdy;
  assign o_bvalid = r.bus.bvalid;
  assign o_bresp = r.bus.bresp;
  assign o_arready = r.bus.arrdy;
  assign o_rvalid = r.bus.rvalid;
  assign o_rdata = r.bus.rdata;
  assign o_rresp = r.bus.rresp;
  assign o_gpio_o = r.gpio_o;
  assign o_gpio_oe = r.gpio_oe;
  assign o_blank = r.blank;
  assign o_restart = r.restart;
  assign o_baud = r.baud_act;

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);

  a_sense_restart: assert property (
    (sense && !r.sense_q && !r.restart) |=> o_restart)
    else $error("host power-up did not restart");
  a_blank_follow: assert property (
    (r.fn[FN_BLANK] && !sense && !r.restart) |=> o_blank)
    else $error("display not blanked with host down");
  a_pwr_idle_float: assert property (
    (o_gpio_oe[PIN_PWR] && !r.ufn[PIN_PWR])
      |-> (r.st == ST_PON || r.st == ST_POFF || r.st == ST_PEXT))
    else $error("power line driven outside a pulse");
  a_wd_zero_off: assert property (
    (r.bus.awrdy && i_awaddr == A_WDOG && i_wstrb[0] && i_wdata[7:0] == 8'h00
      && !r.restart) |=> !wd_act)
    else $error("zero timeout left watchdog on");
  a_wd_expire_rst: assert property (
    (wd_act && r.wd_cnt == 8'h00 && !r.restart)
      |=> (r.st == ST_PRST && !wd_act) ##1 o_gpio_oe[PIN_RST] || r.ufn[PIN_RST])
    else $error("watchdog expiry gave no reset pulse");
  a_pwr_level: assert property (
    (o_gpio_oe[PIN_PWR] && !r.ufn[PIN_PWR] && !r.fn[FN_AUTO] && $stable(r.fn))
      |-> o_gpio_o[PIN_PWR] == r.fn[FN_PINV])
    else $error("power pulse level wrong");
  a_edge_latch: assert property (
    (tick && (i_gpio & ~r.gin) != '0 && !r.restart)
      |=> (r.rise & $past(i_gpio & ~r.gin)) == $past(i_gpio & ~r.gin))
    else $error("rising edge not latched");
  a_pwm_level: assert property (
    r.ufn[GPIO_N-1] |-> o_gpio_o[GPIO_N-1] == (r.pwm_cnt < r.duty[GPIO_N-1]))
    else $error("pwm output wrong");
  a_hold_cancel: assert property (
    (r.st == ST_HOLD_OFF && !i_key_cancel && !wd_act && !r.restart)
      |=> r.st == ST_IDLE)
    else $error("released key did not cancel");
  a_ext_cap: assert property (
    r.st == ST_PEXT |-> r.hold <= EXT_TICKS)
    else $error("extension beyond limit");
endmodule
`default_nettype wire

// ---- shared/hprw_pkg.sv ----
`default_nettype none
package hprw_pkg;
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_HZ = 32;
  localparam int PWM_HZ = 100;
  localparam int PWM_STEPS = 100;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam int PWM_DIV = CLK_HZ / (PWM_HZ * PWM_STEPS);
  localparam int DIV_W = 23;
  // Gesture and pulse times, counted in slow ticks.
  localparam int PWRON_MS = 250;
  localparam int HOLD_S = 4;
  localparam int RSTP_S = 1;
  localparam int EXT_S = 5;
  localparam logic [7:0] PWRON_TICKS = 8'((PWRON_MS * TICK_HZ + 999) / 1000);
  localparam logic [7:0] HOLD_TICKS = 8'(HOLD_S * TICK_HZ);
  localparam logic [7:0] RSTP_TICKS = 8'(RSTP_S * TICK_HZ);
  localparam logic [7:0] EXT_TICKS = 8'(EXT_S * TICK_HZ);
  localparam logic [5:0] SEC_LAST = 6'(TICK_HZ - 1);
  localparam logic [6:0] PWM_LAST = 7'(PWM_STEPS - 1);
  localparam logic [6:0] DUTY_MAX = 7'h64;
  // Register byte offsets.
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_WDOG = 8'h04;
  localparam logic [7:0] A_BAUD = 8'h08;
  localparam logic [7:0] A_GCFG = 8'h0C;
  localparam logic [7:0] A_GSTAT = 8'h10;
  localparam logic [7:0] A_DBG0 = 8'h14;
  localparam logic [7:0] A_DBG1 = 8'h18;
  localparam logic [7:0] A_DBG2 = 8'h1C;
  localparam logic [7:0] A_DBG3 = 8'h20;
  // Function enable bits.
  localparam int FN_AUTO = 0;
  localparam int FN_RINV = 1;
  localparam int FN_PINV = 2;
  localparam int FN_WDACT = 3;
  localparam int FN_BLANK = 4;
  localparam int FN_KRST = 5;
  localparam int FN_KON = 6;
  localparam int FN_KOFF = 7;
  localparam int GPIO_N = 5;
  localparam int PIN_SENSE = 1;
  localparam int PIN_PWR = 2;
  localparam int PIN_RST = 3;
  localparam logic [7:0] FN_RST = 8'h01;
  localparam logic [7:0] PLEN_RST = 8'h20;
  localparam logic [17:0] BAUD_RST = 18'h0_4B00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE, ST_HOLD_ON, ST_HOLD_OFF, ST_HOLD_RST, ST_PON, ST_POFF, ST_PEXT, ST_PRST
  } hprw_st_t;
endpackage
`default_nettype wire

// ---- verif/hprw_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module hprw_host_model (
  // Pin drive from the design
  input wire logic [hprw_pkg::GPIO_N-1:0] i_gpio_o,
  input wire logic [hprw_pkg::GPIO_N-1:0] i_gpio_oe,
  // Host state and outside levels
  input wire logic i_host_on,
  input wire logic [hprw_pkg::GPIO_N-1:0] i_ext_lvl,
  // Levels seen by the design
  output logic [hprw_pkg::GPIO_N-1:0] o_gpio,
  output logic o_rail_sense
);
  import hprw_pkg::*;
  // Host switch inputs carry pull-ups, so a released line reads high, never the last driven level.
  always_comb begin
    o_rail_sense = i_host_on;
    for (int p = 0; p < GPIO_N; p++) begin
      if (i_gpio_oe[p]) begin
        o_gpio[p] = i_gpio_o[p];
      end else if (p == PIN_PWR || p == PIN_RST) begin
        o_gpio[p] = 1'b1;
      end else begin
        o_gpio[p] = i_ext_lvl[p];
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb_host_power_reset_watchdog.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: %s got %0h want %0h", $time, tname, g, e); end end
module tb_host_power_reset_watchdog;
  import hprw_pkg::*;
  localparam int T = 8;
  logic i_ref_clk = 1'b0;
  logic i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [7:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, o_rdata, rd;
  logic [3:0] i_wstrb;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, lvl;
  logic [1:0] o_bresp, o_rresp, rsp;
  logic [GPIO_N-1:0] i_gpio, o_gpio_o, o_gpio_oe, ext, oe_q;
  logic i_rail_sense, i_key_confirm, i_key_cancel, o_blank, o_restart, host_on;
  logic [17:0] o_baud, baud_b;
  int mismatches = 0, n_tests = 0, restarts = 0, rpulses = 0, lat, dur, r0, hi;
  string tname;
  int duty[3] = '{0, 30, 100};
  // ==========================================================
  // Design and host
  hprw_top #(.TICK_DIV(T), .PWM_DIV(2)) DUT (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr), .i_wvalid(i_wvalid),
    .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .i_gpio(i_gpio), .o_gpio_o(o_gpio_o), .o_gpio_oe(o_gpio_oe),
    .i_rail_sense(i_rail_sense), .i_key_confirm(i_key_confirm), .i_key_cancel(i_key_cancel),
    .o_blank(o_blank), .o_restart(o_restart), .o_baud(o_baud));
  hprw_host_model HOST (.i_gpio_o(o_gpio_o), .i_gpio_oe(o_gpio_oe), .i_host_on(host_on),
    .i_ext_lvl(ext), .o_gpio(i_gpio), .o_rail_sense(i_rail_sense));
  always #2 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    oe_q <= o_gpio_oe;
    if (o_restart === 1'b1) restarts++;
    if (o_gpio_oe[PIN_RST] === 1'b1 && oe_q[PIN_RST] !== 1'b1) rpulses++;
  end
  // ==========================================================
  // Bus and pin tasks
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= s;
    i_bready <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_awready !== 1'b1 && n < 50);
    i_awvalid <= 1'b0;
    i_wvalid <= 1'b0;
    while (o_bvalid !== 1'b1 && n < 100) begin
      @(posedge i_ref_clk);
      n++;
    end
    rsp = o_bresp;
    baud_b = o_baud;
    i_bready <= 1'b0;
    `CHK(n < 100, 1'b1)
  endtask
  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_arvalid <= 1'b1;
    i_araddr <= a;
    i_rready <= 1'b1;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (o_arready !== 1'b1 && n < 50);
    i_arvalid <= 1'b0;
    while (o_rvalid !== 1'b1 && n < 100) begin
      @(posedge i_ref_clk);
      n++;
    end
    rd = o_rdata;
    rsp = o_rresp;
    i_rready <= 1'b0;
    `CHK(n < 100, 1'b1)
  endtask
  // Waits for a pulse on pin p, then measures how long the pin stays driven.
  task automatic pulse(input int p, input int maxw);
    lat = 0;
    dur = 0;
    while (o_gpio_oe[p] !== 1'b1 && lat < maxw) begin
      lat++;
      @(posedge i_ref_clk);
    end
    lvl = o_gpio_o[p];
    while (o_gpio_oe[p] === 1'b1 && dur < 3000) begin
      dur++;
      @(posedge i_ref_clk);
    end
  endtask
  function automatic logic near(input int v, input int ticks);
    return v >= ticks * T - 8 && v <= ticks * T + 12;
  endfunction
  task automatic fin;
    $display("test %s done", tname);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge i_ref_clk);
    mismatches++;
    wrap_up;
  end
  // ==========================================================
  // Tests
  initial begin
    {i_rst_b, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    {i_awaddr, i_araddr, i_wdata, i_wstrb, i_key_confirm, i_key_cancel} = '0;
    host_on = 1'b1;
    ext = 5'h02;
    repeat (16) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    tname = "reset";
    `CHK(o_gpio_oe, 5'h00)
    `CHK(o_baud, BAUD_RST)
    axr(A_CFG);
    `CHK(rd, 32'h0001_2001)
    axr(A_WDOG);
    `CHK(rd[8], 1'b0)
    axr(8'h40);
    `CHK(rsp, RESP_SLVERR)
    `CHK(rd, 32'h0000_0000)
    axw(8'h44, 32'h0000_0001, 4'hF);
    `CHK(rsp, RESP_SLVERR)
    fin;
    tname = "power off";
    axw(A_CFG, 32'hFFFF_FFF6, 4'h1);
    `CHK(rsp, RESP_OKAY)
    axw(A_CFG, 32'h0000_0400, 4'h2);
    axr(A_CFG);
    `CHK(rd, 32'h0001_04F6)
    `CHK(o_blank, 1'b0)
    i_key_cancel <= 1'b1;
    pulse(PIN_PWR, 1200);
    `CHK(near(lat, 128), 1'b1)
    `CHK(lvl, 1'b1)
    `CHK(near(dur, 164), 1'b1)
    i_key_cancel <= 1'b0;
    `CHK(o_gpio_oe[PIN_PWR], 1'b0)
    fin;
    tname = "key reset";
    i_key_confirm <= 1'b1;
    repeat (64) @(posedge i_ref_clk);
    i_key_confirm <= 1'b0;
    pulse(PIN_RST, 1200);
    `CHK(dur, 0)
    r0 = restarts;
    i_key_confirm <= 1'b1;
    pulse(PIN_RST, 1200);
    `CHK(near(lat, 128), 1'b1)
    `CHK(lvl, 1'b1)
    `CHK(near(dur, 32), 1'b1)
    i_key_confirm <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    `CHK(restarts - r0, 1)
    fin;
    tname = "power on";
    axw(A_CFG, 32'h0000_0451, 4'h3);
    host_on <= 1'b0;
    repeat (24) @(posedge i_ref_clk);
    `CHK(o_blank, 1'b1)
    r0 = restarts;
    i_key_confirm <= 1'b1;
    pulse(PIN_PWR, 300);
    `CHK(near(lat, 8), 1'b1)
    `CHK(lvl, 1'b0)
    `CHK(near(dur, 4), 1'b1)
    i_key_confirm <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    `CHK(restarts - r0, 1)
    r0 = restarts;
    host_on <= 1'b1;
    repeat (24) @(posedge i_ref_clk);
    `CHK(restarts - r0, 1)
    fin;
    tname = "sense pin";
    axw(A_CFG, 32'h0000_2011, 4'h7);
    ext[1] <= 1'b0;
    repeat (24) @(posedge i_ref_clk);
    `CHK(o_blank, 1'b1)
    r0 = restarts;
    ext[1] <= 1'b1;
    repeat (24) @(posedge i_ref_clk);
    `CHK(o_blank, 1'b0)
    `CHK(restarts - r0, 1)
    fin;
    tname = "watchdog";
    axw(A_WDOG, 32'h0000_0002, 4'h1);
    axr(A_WDOG);
    `CHK(rd[8:0], 9'h102)
    axr(A_DBG1);
    `CHK(rd[31:24], 8'h09)
    axr(A_DBG2);
    `CHK(rd[7:0], 8'h02)
    `CHK(rd[31:24], 8'h01)
    r0 = rpulses;
    repeat (2) begin
      repeat (200) @(posedge i_ref_clk);
      axw(A_WDOG, 32'h0000_0002, 4'h1);
    end
    `CHK(rpulses - r0, 0)
    r0 = restarts;
    pulse(PIN_RST, 700);
    `CHK(lat >= 250 && lat <= 530, 1'b1)
    `CHK(lvl, 1'b0)
    `CHK(near(dur, 32), 1'b1)
    `CHK(restarts - r0, 0)
    axr(A_WDOG);
    `CHK(rd[8], 1'b0)
    axw(A_WDOG, 32'h0000_0002, 4'h1);
    axw(A_WDOG, 32'h0000_0000, 4'h1);
    r0 = rpulses;
    repeat (700) @(posedge i_ref_clk);
    `CHK(rpulses - r0, 0)
    fin;
    tname = "baud";
    axw(A_BAUD, 32'h0000_9600, 4'hF);
    `CHK(baud_b, BAUD_RST)
    // The new rate lands at the response edge itself, so look one edge later.
    @(posedge i_ref_clk);
    `CHK(o_baud, 18'h0_9600)
    fin;
    tname = "pins";
    ext[0] <= 1'b1;
    repeat (3 * T + 4) @(posedge i_ref_clk);
    axr(A_GSTAT);
    `CHK({rd[8], rd[0]}, 2'b11)
    axr(A_GSTAT);
    `CHK(rd[8], 1'b0)
    ext[0] <= 1'b0;
    repeat (3 * T + 4) @(posedge i_ref_clk);
    axr(A_GSTAT);
    `CHK({rd[16], rd[0]}, 2'b10)
    foreach (duty[k]) begin
      axw(A_GCFG, 32'h0001_0004 | (32'(duty[k]) << 8), 4'hF);
      repeat (400) @(posedge i_ref_clk);
      hi = 0;
      repeat (400) begin
        @(posedge i_ref_clk);
        if (o_gpio_oe[4] === 1'b1 && o_gpio_o[4] === 1'b1) hi++;
      end
      `CHK(hi, 4 * duty[k])
    end
    fin;
    wrap_up;
  end
endmodule
`default_nettype wire
